// ---- verilog/cvm_code_violation_monitor.sv ----
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
module cvm_code_violation_monitor
  import cvm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Command/indicate channel from the controller
  input wire logic ciWrite,
  input wire logic [3:0] ciCode,
  // Monitor channel read of the counter
  input wire logic monReadReq,
  input wire logic actStateOk,
  output logic monAck,
  output logic monRefused,
  output logic [7:0] monData,
  // Line deactivation
  input wire logic lineDeact,
  // Receive symbols from the hybrid front end
  input wire logic rxSymValid,
  input wire logic [1:0] lineInSym,
  input wire logic rxUserSym,
  input wire logic rxFrameStart,
  input wire logic rxFrameEnd,
  input wire logic rxMaintPos,
  // Transmit symbols from the line coder
  input wire logic [1:0] txSym,
  input wire logic [6:0] txSymPos,
  output logic [1:0] lineOutSym,
  output logic txMaintPos,
  output logic loopActive
);

  // ----------------------------------------------------------------
  // Internal carriers
  // ----------------------------------------------------------------
  cvm_sym_if symIf(); // To the running-sum monitor
  cvm_cnt_if cntIf(); // To the error counter

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] mode_r; // Operating mode
  logic [IRQ_W-1:0] irqStat_r; // Sticky events
  logic [IRQ_W-1:0] irqMask_r; // Event enables
  logic ack_r; // Bus answer
  logic [31:0] rdData_r; // Bus read data
  logic loop_r; // Test loop closed
  logic cntEn_r; // Counting enabled
  logic frameViol_r; // Violation in current frame
  logic frameMaint_r; // Positive M seen in frame
  logic maintFlag_r; // Report upstream in next slot
  logic txMaint_r; // Registered M output
  logic monAck_r; // Monitor read answer
  logic monRef_r; // Monitor read refused
  logic [7:0] monData_r; // Monitor read data
  logic [7:0] prevCount_r; // For saturation edge
  logic busReq; // Valid bus access this cycle
  logic busWr; // Write access
  logic busRd; // Read access
  logic ntSide; // NT or repeater mode
  logic ltSide; // LT mode
  logic frameIncr; // Frame counts once
  logic monOk; // Read permitted
  logic [IRQ_W-1:0] irqEvt; // Raw event pulses
  logic [IRQ_W-1:0] irqClr; // Write-one-to-clear bits

  // Decode of the mode field, used by the mode decode below
  function automatic logic isNtSide(input logic [1:0] m);
    isNtSide = (m == MODE_NT) || (m == MODE_RP);
  endfunction : isNtSide

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Reserved code 3 falls back to LT behaviour
  always_comb begin
    ntSide = isNtSide(mode_r);
    ltSide = !isNtSide(mode_r);
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state; ack drops in the cycle after it was given
  always_comb begin
    busReq = wb_cyc_i && wb_stb_i && !ack_r;
    busWr = busReq && wb_we_i;
    busRd = busReq && !wb_we_i;
  end

  // Answer every access, mapped or not
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq;
    end
  end

  // Mode register, low byte lane only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_r <= CTRL_RESET;
    end else if (busWr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      mode_r <= wb_dat_i[CTRL_MODE_LSB +: 2];
    end
  end

  // Mask register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irqMask_r <= IRQ_MASK_RESET;
    end else if (busWr && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
      irqMask_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdData_r <= 32'h0000_0000;
    end else if (busRd) begin
      unique case (wb_adr_i)
        REG_CTRL: rdData_r <= {30'h0, mode_r};
        REG_STATUS: rdData_r <= {29'h0, maintFlag_r, cntEn_r, loop_r};
        REG_IRQ_STAT: rdData_r <= {29'h0, irqStat_r};
        REG_IRQ_MASK: rdData_r <= {29'h0, irqMask_r};
        REG_ERRCNT: rdData_r <= {24'h0, cntIf.count};
        default: rdData_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_dat_o = rdData_r;
  assign wb_ack_o = ack_r;

  // ----------------------------------------------------------------
  // Test loops
  // ----------------------------------------------------------------
  // Any other code or a deactivation opens the loop again
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      loop_r <= 1'b0;
    end else if (lineDeact) begin
      loop_r <= 1'b0;
    end else if (ciWrite) begin
      loop_r <= (ciCode == CI_LOOP);
    end
  end

  // Transmit path is never cut, so the far end stays synced
  assign lineOutSym = txSym;
  // Data path uses this to return B, B and D as one unit
  assign loopActive = loop_r;

  // Receiver input: driver output when looped, hybrid otherwise
  always_comb begin
    symIf.symValid = rxSymValid;
    symIf.sym = loop_r ? txSym : lineInSym;
    symIf.userSym = rxUserSym;
    symIf.frameStart = rxFrameStart;
  end

  cvm_rds_monitor u_rds (
    .coreClk(core_clk),
    .reset(reset),
    .s(symIf.mon)
  );

  // ----------------------------------------------------------------
  // Frame accumulation
  // ----------------------------------------------------------------
  // Several events in one frame fold into one count
  always_comb begin
    frameIncr = rxFrameEnd && (frameViol_r || symIf.violation ||
                (ltSide && (frameMaint_r || rxMaintPos)));
  end

  // Per-frame flags, restarted at frame end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frameViol_r <= 1'b0;
      frameMaint_r <= 1'b0;
    end else if (rxFrameEnd) begin
      frameViol_r <= 1'b0;
      frameMaint_r <= 1'b0;
    end else begin
      if (symIf.violation) begin
        frameViol_r <= 1'b1;
      end
      if (rxMaintPos) begin
        frameMaint_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Upstream maintenance symbol
  // ----------------------------------------------------------------
  // Flag of the last completed frame goes out in the next slot
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      maintFlag_r <= 1'b0;
    end else if (rxFrameEnd) begin
      maintFlag_r <= frameViol_r || symIf.violation;
    end
  end

  // Registered so the coder sees a clean flag at the slot
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      txMaint_r <= 1'b0;
    end else begin
      txMaint_r <= ntSide && maintFlag_r &&
                   (txSymPos == MAINT_POS);
    end
  end

  assign txMaintPos = txMaint_r;

  // ----------------------------------------------------------------
  // Counter enable
  // ----------------------------------------------------------------
  // Stops at deactivation; mode picks the code that resumes it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cntEn_r <= 1'b0;
    end else if (lineDeact) begin
      cntEn_r <= 1'b0;
    end else if (ciWrite) begin
      if (ltSide && (ciCode == CI_SYNC_DONE || ciCode == CI_ACT_UP)) begin
        cntEn_r <= 1'b1;
      end else if (ntSide && ciCode == CI_ACT_DOWN) begin
        cntEn_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error counter and monitor read
  // ----------------------------------------------------------------
  // Repeater mode and early activation states refuse the read
  always_comb begin
    monOk = monReadReq && (mode_r != MODE_RP) && actStateOk;
    cntIf.incr = frameIncr;
    cntIf.enable = cntEn_r && !lineDeact;
    cntIf.clear = monOk || lineDeact;
  end

  cvm_err_counter u_cnt (
    .coreClk(core_clk),
    .reset(reset),
    .c(cntIf.cnt)
  );

  // Value read and cleared in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      monAck_r <= 1'b0;
      monRef_r <= 1'b0;
      monData_r <= 8'h00;
    end else begin
      monAck_r <= monOk;
      monRef_r <= monReadReq && !monOk;
      if (monOk) begin
        monData_r <= cntIf.count;
      end
    end
  end

  assign monAck = monAck_r;
  assign monRefused = monRef_r;
  assign monData = monData_r;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Previous count lets saturation fire once per climb
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prevCount_r <= 8'h00;
    end else begin
      prevCount_r <= cntIf.count;
    end
  end

  always_comb begin
    irqEvt = '0;
    irqEvt[IRQ_VIOL] = frameIncr;
    irqEvt[IRQ_SAT] = (cntIf.count == CNT_MAX) && (prevCount_r != CNT_MAX);
    irqEvt[IRQ_LOOP] = (lineDeact && loop_r) ||
                       (!lineDeact && ciWrite && ((ciCode == CI_LOOP) != loop_r));
    irqClr = '0;
    if (busWr && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) begin
      irqClr = wb_dat_i[IRQ_W-1:0];
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

endmodule : cvm_code_violation_monitor

// ---- verilog/cvm_pkg.sv ----
package cvm_pkg;

  // ----------------------------------------------------------------
  // Symbol and mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SYM_ZERO = 2'h0; // Ternary 0
  localparam logic [1:0] SYM_PLUS = 2'h1; // Ternary +
  localparam logic [1:0] SYM_MINUS = 2'h3; // Ternary -
  localparam logic [1:0] MODE_LT = 2'h0; // line_termination_mode
  localparam logic [1:0] MODE_NT = 2'h1; // network_termination_mode
  localparam logic [1:0] MODE_RP = 2'h2; // repeater_mode

  // ----------------------------------------------------------------
  // Line code geometry
  // ----------------------------------------------------------------
  localparam int SYMS_PER_BLOCK = 3; // Ternary symbols per 4-bit block
  localparam int USER_SYMS = 108; // User symbols per frame
  localparam logic [6:0] MAINT_POS = 7'h19; // Upstream position 25
  localparam logic signed [3:0] SUM_MIN = 4'sh1; // Lowest column
  localparam logic signed [3:0] SUM_MAX = 4'sh4; // Highest column
  localparam logic signed [3:0] SUM_RESET = 4'sh1; // Start column
  localparam logic [7:0] CNT_MAX = 8'hff; // Saturation value

  // ----------------------------------------------------------------
  // Command/indicate codes (values chosen locally)
  // ----------------------------------------------------------------
  localparam logic [3:0] CI_LOOP = 4'h8; // Close external loop
  localparam logic [3:0] CI_SYNC_DONE = 4'h4; // sync_done_indication
  localparam logic [3:0] CI_ACT_UP = 4'hc; // activation_indication_upstream
  localparam logic [3:0] CI_ACT_DOWN = 4'hd; // activation_indication_downstream

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // Mode select
  localparam logic [7:0] REG_STATUS = 8'h04; // Live state
  localparam logic [7:0] REG_IRQ_STAT = 8'h08; // Sticky events, W1C
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c; // Event enables
  localparam logic [7:0] REG_ERRCNT = 8'h10; // Counter, no clear
  localparam int CTRL_MODE_LSB = 0; // Mode field low bit
  localparam logic [1:0] CTRL_RESET = 2'h0; // Resets to LT
  localparam int ST_LOOP = 0; // Loop closed
  localparam int ST_CNT_EN = 1; // Counting enabled
  localparam int ST_MAINT = 2; // Maintenance flag pending
  localparam int IRQ_VIOL = 0; // Violating frame seen
  localparam int IRQ_SAT = 1; // Counter reached 255
  localparam int IRQ_LOOP = 2; // Loop state changed
  localparam int IRQ_W = 3; // Event count
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0; // All masked

endpackage : cvm_pkg

// ---- verilog/cvm_ifs.sv ----
// ------------------------------------------------------------------
// Received symbol stream into the running-sum monitor
// ------------------------------------------------------------------
interface cvm_sym_if;
  logic symValid; // One received symbol this cycle
  logic [1:0] sym; // Ternary symbol
  logic userSym; // Symbol belongs to user data
  logic frameStart; // First symbol of a frame
  logic violation; // Pulse: block broke the code
  modport core (output symValid, sym, userSym, frameStart,
                input violation);
  modport mon (input symValid, sym, userSym, frameStart,
               output violation);
endinterface : cvm_sym_if

// ------------------------------------------------------------------
// Error counter control
// ------------------------------------------------------------------
interface cvm_cnt_if;
  logic incr; // Pulse: count one frame
  logic clear; // Pulse: zero the count
  logic enable; // Counting allowed
  logic [7:0] count; // Current count
  modport core (output incr, clear, enable, input count);
  modport cnt (input incr, clear, enable, output count);
endinterface : cvm_cnt_if

// ---- verilog/cvm_rds_monitor.sv ----
module cvm_rds_monitor
  import cvm_pkg::*;
(
  input wire logic coreClk,
  input wire logic reset,
  cvm_sym_if.mon s
);

  // ----------------------------------------------------------------
  // Block tracking
  // ----------------------------------------------------------------
  logic signed [3:0] sum_r; // Running digital sum
  logic [1:0] pos_r; // Symbol index in block
  logic allZero_r; // Block so far all zero
  logic viol_r; // Violation pulse
  logic signed [3:0] sumNxt; // Sum including this symbol
  logic zeroNxt; // All-zero including this symbol
  logic lastSym; // Third symbol of a block

  // Polarity as +1, 0 or -1
  function automatic logic signed [3:0] polarity(input logic [1:0] v);
    unique case (v)
      SYM_PLUS: polarity = 4'sh1;
      SYM_MINUS: polarity = -4'sh1;
      default: polarity = 4'sh0;
    endcase
  endfunction : polarity

  // A block restart at frame start keeps sync symbols out
  always_comb begin
    sumNxt = sum_r + polarity(s.sym);
    zeroNxt = (s.frameStart ? 1'b1 : allZero_r) && (s.sym != SYM_PLUS)
              && (s.sym != SYM_MINUS);
    lastSym = (s.frameStart ? 2'h0 : pos_r) == 2'(SYMS_PER_BLOCK - 1);
  end

  // Only user symbols advance the block
  always_ff @(posedge coreClk or posedge reset) begin
    if (reset) begin
      sum_r <= SUM_RESET;
      pos_r <= 2'h0;
      allZero_r <= 1'b1;
      viol_r <= 1'b0;
    end else begin
      viol_r <= 1'b0;
      if (s.symValid && s.userSym) begin
        if (lastSym) begin
          pos_r <= 2'h0;
          allZero_r <= 1'b1;
          // Out of range or 0 0 0
          viol_r <= (sumNxt < SUM_MIN) || (sumNxt > SUM_MAX) || zeroNxt;
          // Clamp so one error does not cascade
          if (sumNxt < SUM_MIN) begin
            sum_r <= SUM_MIN;
          end else if (sumNxt > SUM_MAX) begin
            sum_r <= SUM_MAX;
          end else begin
            sum_r <= sumNxt;
          end
        end else begin
          pos_r <= (s.frameStart ? 2'h0 : pos_r) + 2'h1;
          allZero_r <= zeroNxt;
          sum_r <= sumNxt;
        end
      end else if (s.symValid && s.frameStart) begin
        pos_r <= 2'h0;
        allZero_r <= 1'b1;
      end
    end
  end

  assign s.violation = viol_r;

endmodule : cvm_rds_monitor

// ---- verilog/cvm_err_counter.sv ----
module cvm_err_counter
  import cvm_pkg::*;
(
  input wire logic coreClk,
  input wire logic reset,
  cvm_cnt_if.cnt c
);

  // ----------------------------------------------------------------
  // Saturating frame error counter
  // ----------------------------------------------------------------
  logic [7:0] count_r; // Eight-bit count

  // Increment beats a coinciding clear so no frame is lost
  always_ff @(posedge coreClk or posedge reset) begin
    if (reset) begin
      count_r <= 8'h00;
    end else if (c.incr && c.enable) begin
      if (c.clear) begin
        count_r <= 8'h01;
      end else if (count_r != CNT_MAX) begin
        count_r <= count_r + 8'h01;
      end
    end else if (c.clear) begin
      count_r <= 8'h00;
    end
  end

  assign c.count = count_r;

endmodule : cvm_err_counter

// ---- dv/cvm_checker.sv ----
module cvm_checker
  import cvm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ciWrite,
  input wire logic [3:0] ciCode,
  input wire logic monReadReq,
  input wire logic actStateOk,
  input wire logic monAck,
  input wire logic monRefused,
  input wire logic lineDeact,
  input wire logic [1:0] txSym,
  input wire logic [6:0] txSymPos,
  input wire logic [1:0] lineOutSym,
  input wire logic txMaintPos,
  input wire logic loopActive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // One clock domain, so one default clocking and disable
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Ack exactly one cycle after the take, then gone
  a_bus_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing wrong");
  // Transparent loops: the line keeps sending
  a_line_transparent: assert property (
    lineOutSym == txSym) else $error("line output not transmitted");
  a_loop_close: assert property (
    ciWrite && ciCode == CI_LOOP && !lineDeact |=> loopActive)
    else $error("loop did not close");
  a_loop_open: assert property (
    ciWrite && ciCode != CI_LOOP |=> !loopActive)
    else $error("loop did not open");
  // Every counter read is answered one way or the other
  a_mon_answer: assert property (
    monReadReq |=> monAck != monRefused)
    else $error("counter read not answered once");
  a_mon_refuse: assert property (
    monReadReq && !actStateOk |=> monRefused)
    else $error("counter read not refused");
  a_mon_quiet: assert property (
    !monReadReq |=> !monAck && !monRefused)
    else $error("counter answer without read");
  // Maintenance symbol only in its slot
  a_maint_slot: assert property (
    txMaintPos |-> $past(txSymPos) == MAINT_POS)
    else $error("maintenance symbol off slot");
endmodule : cvm_checker

// ---- dv/cvm_far_end.sv ----
module cvm_far_end
  import cvm_pkg::*;
(
  input wire logic core_clk,
  output logic rxSymValid,
  output logic [1:0] lineInSym,
  output logic rxUserSym,
  output logic rxFrameStart,
  output logic rxFrameEnd,
  output logic rxMaintPos
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Remote transmitter: quiet until asked for a frame
  // ----------------------------------------------------------------
  initial begin
    rxSymValid = 1'b0;
    lineInSym = 2'h2;
    rxUserSym = 1'b0;
    rxFrameStart = 1'b0;
    rxFrameEnd = 1'b0;
    rxMaintPos = 1'b0;
  end

  // Sends n user symbols, first in low bits, whole blocks of three
  task automatic send_frame(input logic [17:0] s, input int n,
                            input logic m);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rxSymValid <= 1'b1;
      rxUserSym <= 1'b1;
      rxFrameStart <= (i == 0);
      lineInSym <= s[2*i +: 2];
    end
    @(posedge core_clk);
    rxSymValid <= 1'b0;
    rxUserSym <= 1'b0;
    rxFrameStart <= 1'b0;
    // Idle line toggles so a stale symbol is never reused
    lineInSym <= ~lineInSym;
    rxMaintPos <= m;
    @(posedge core_clk);
    rxMaintPos <= 1'b0;
    // Frame end two cycles late so the last block is judged
    @(posedge core_clk);
    rxFrameEnd <= 1'b1;
    @(posedge core_clk);
    rxFrameEnd <= 1'b0;
  endtask : send_frame
endmodule : cvm_far_end

// ---- dv/tb_top.sv ----
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb_top
  import cvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, irq, ciWrite = 0, monReadReq = 0, actStateOk = 0;
  logic [3:0] ciCode = 4'h0;
  logic monAck, monRefused, lineDeact = 0, rxSymValid, rxUserSym;
  logic [7:0] monData;
  logic [1:0] lineInSym, txSym = 2'h0, lineOutSym;
  logic rxFrameStart, rxFrameEnd, rxMaintPos, txMaintPos, loopActive;
  logic [6:0] txSymPos = 7'h00;
  int mismatches = 0, n_checks = 0;
  // Frames: neutral, two zero blocks, sum above four, sum below one
  localparam logic [17:0] FOK = {12'h0, SYM_ZERO, SYM_MINUS, SYM_PLUS};
  localparam logic [17:0] FHI = {{3{SYM_MINUS}}, {6{SYM_PLUS}}};
  localparam logic [17:0] FLO = {{3{SYM_MINUS}}, {3{SYM_PLUS}},
                                 {3{SYM_MINUS}}};

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #2.5 core_clk = ~core_clk;
  cvm_code_violation_monitor dut (.core_clk, .reset, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .irq, .ciWrite, .ciCode, .monReadReq, .actStateOk,
    .monAck, .monRefused, .monData, .lineDeact, .rxSymValid,
    .lineInSym, .rxUserSym, .rxFrameStart, .rxFrameEnd, .rxMaintPos,
    .txSym, .txSymPos, .lineOutSym, .txMaintPos, .loopActive);
  cvm_far_end far (.core_clk, .rxSymValid, .lineInSym, .rxUserSym,
    .rxFrameStart, .rxFrameEnd, .rxMaintPos);

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 50) mismatches++;
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask : rd
  task automatic ci(input logic [3:0] c);
    @(posedge core_clk);
    ciWrite <= 1'b1;
    ciCode <= c;
    @(posedge core_clk);
    ciWrite <= 1'b0;
  endtask : ci
  // Counter read over the monitor channel
  task automatic mon(input logic ok, input logic acc,
                     input logic [7:0] e);
    @(posedge core_clk);
    actStateOk <= ok;
    monReadReq <= 1'b1;
    @(posedge core_clk);
    monReadReq <= 1'b0;
    @(posedge core_clk);
    `CHK("monAck", acc, monAck)
    `CHK("monRefused", ~acc, monRefused)
    if (acc) `CHK("monData", e, monData)
  endtask : mon
  task automatic chk1(input string nm, input logic e);
    @(posedge core_clk);
    `CHK(nm, e, (nm == "irq") ? irq : txMaintPos)
  endtask : chk1
  task automatic slot(input logic e);
    @(posedge core_clk);
    txSymPos <= MAINT_POS;
    @(posedge core_clk);
    txSymPos <= 7'h00;
    chk1("txMaintPos", e);
  endtask : slot
  task automatic deact();
    @(posedge core_clk);
    lineDeact <= 1'b1;
    @(posedge core_clk);
    lineDeact <= 1'b0;
  endtask : deact
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Cuts a hang short
  initial begin
    repeat (12000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd("ctrl", REG_CTRL, 32'h0);
    rd("mask", REG_IRQ_MASK, 32'h0);
    rd("istat", REG_IRQ_STAT, 32'h0);
    wb(1'b1, REG_ERRCNT, 32'h55);
    rd("errcnt", REG_ERRCNT, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    // Counting off until the right code; NT code ignored in LT
    far.send_frame(18'h0, 3, 1'b0);
    ci(CI_ACT_DOWN);
    far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h0);
    ci(CI_SYNC_DONE);
    wb(1'b1, REG_IRQ_MASK, 32'h1);
    $display("test reset_idle done");
    far.send_frame(FOK, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h0);
    far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h1);
    far.send_frame(18'h0, 6, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h2);
    far.send_frame(FHI, 9, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h3);
    far.send_frame(FLO, 9, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h4);
    far.send_frame(FOK, 3, 1'b1);
    rd("errcnt", REG_ERRCNT, 32'h5);
    far.send_frame(18'h0, 3, 1'b1);
    rd("errcnt", REG_ERRCNT, 32'h6);
    chk1("irq", 1'b1);
    rd("istat", REG_IRQ_STAT, 32'h1);
    wb(1'b1, REG_IRQ_STAT, 32'h1);
    chk1("irq", 1'b0);
    $display("test violations done");
    mon(1'b0, 1'b0, 8'h00);
    rd("errcnt", REG_ERRCNT, 32'h6);
    mon(1'b1, 1'b1, 8'h06);
    rd("errcnt", REG_ERRCNT, 32'h0);
    repeat (256) far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'hff);
    rd("istat", REG_IRQ_STAT, 32'h3);
    wb(1'b1, REG_CTRL, {30'h0, MODE_RP});
    mon(1'b1, 1'b0, 8'h00);
    rd("errcnt", REG_ERRCNT, 32'hff);
    $display("test saturate_read done");
    deact();
    rd("errcnt", REG_ERRCNT, 32'h0);
    wb(1'b1, REG_CTRL, {30'h0, MODE_NT});
    ci(CI_SYNC_DONE);
    far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h0);
    ci(CI_ACT_DOWN);
    far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h1);
    slot(1'b1);
    far.send_frame(FOK, 3, 1'b1);
    rd("errcnt", REG_ERRCNT, 32'h1);
    slot(1'b0);
    $display("test nt_mode done");
    wb(1'b1, REG_CTRL, {30'h0, MODE_LT});
    deact();
    ci(CI_ACT_UP);
    far.send_frame(18'h0, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h1);
    wb(1'b1, REG_IRQ_STAT, 32'h7);
    ci(CI_LOOP);
    chk1("irq", 1'b0);
    `CHK("loopActive", 1'b1, loopActive)
    rd("istat", REG_IRQ_STAT, 32'h4);
    rd("status", REG_STATUS, 32'h7);
    for (int i = 1; i < 4; i++) begin
      @(posedge core_clk);
      txSym <= i[1:0];
      @(posedge core_clk);
      `CHK("lineOutSym", i[1:0], lineOutSym)
    end
    // Far end sends a clean block; looped zeros must be judged
    txSym <= SYM_ZERO;
    far.send_frame(FOK, 3, 1'b0);
    rd("errcnt", REG_ERRCNT, 32'h2);
    wb(1'b1, REG_IRQ_STAT, 32'h7);
    ci(CI_SYNC_DONE);
    chk1("irq", 1'b0);
    `CHK("loopActive", 1'b0, loopActive)
    $display("test loops done");
    finish_test();
  end
endmodule : tb_top

bind cvm_code_violation_monitor cvm_checker chk (.core_clk, .reset,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ciWrite, .ciCode, .monReadReq,
  .actStateOk, .monAck, .monRefused, .lineDeact, .txSym, .txSymPos,
  .lineOutSym, .txMaintPos, .loopActive);
